//--- gpcs_top.sv
// What this block does
// RULE1 - No carrier extension, bursting or low power idle
// RULE2 - Send start group instead of first preamble byte
// RULE3 - End frame with T R R or T R
// RULE4 - Send idle groups whenever no frame
// RULE5 - Transmit error becomes error code group
// RULE6 - Encode bytes to balanced ten-bit symbols
// RULE7 - Search commas and realign to their boundary
// RULE8 - Comma search restarts when sync lost
// RULE9 - Decode with running disparity check
// RULE10 - Idle then start opens frame, send 0x55
// RULE11 - Forward bytes until T R ends frame
// RULE12 - Received error group flagged to MAC
// RULE13 - Other pairs outside frame are false carrier
// RULE14 - Invalid character inside frame flags error
// RULE15 - Sync after three clean comma groups
// RULE16 - Errors and misplaced commas raise error count
// RULE17 - Four good characters lower error count
// RULE18 - Error count of four loses sync
// RULE19 - Link indicator high while synchronised
// RULE20 - Panel link only without auto-negotiation
// RULE21 - Carrier sense when synced and machines active
// RULE22 - Collision only in SGMII half duplex
// RULE23 - Negative disparity at reset, standard code tables
`timescale 1ns/10ps
`default_nettype none
`include "gpcs_map.svh"

module gpcs_top
  import gpcs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_gmii_txd,
  input  wire logic       i_gmii_tx_en,
  input  wire logic       i_mac_tx_error_in,
  input  wire logic [9:0] i_tbi_rx,
  input  wire logic       i_sgmii_mode,
  input  wire logic       i_half_duplex,
  input  wire logic       i_an_enable,
  output logic      [9:0] o_tbi_tx,
  output logic      [7:0] o_gmii_rxd,
  output logic            o_gmii_rx_dv,
  output logic            o_gmii_rx_er,
  output logic            o_rx_crs,
  output logic            o_rx_col,
  output logic            o_led_link,
  output logic            o_led_panel_link,
  output logic            o_led_crs,
  output logic            o_led_col
);

  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // Legal control characters
  function automatic logic kvalid(input logic [7:0] b);
    logic [4:0] x;
    x = b[4:0];
    kvalid = (x == 5'h1C) ||
             (b[7:5] == 3'h7 && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
  endfunction

  // Returns {running disparity after, abcdei fghj}, bit 9 sent first
  function automatic logic [10:0] enc(input gpcs_char_t c, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [4:0] x;
    logic [2:0] y;
    logic       rd1;
    logic       rd2;
    logic       alt;
    logic       k28;
    x   = c.d[4:0];
    y   = c.d[7:5];
    k28 = c.k && x == 5'h1C;
    s6  = k28 ? 6'h0F : T6[x];
    if (rd && ($countones(s6) != 3 || s6 == 6'h38)) begin
      s6 = ~s6;
    end
    rd1 = ($countones(s6) != 3) ? ~rd : rd;
    alt = y == 3'h7 && (c.k || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rd1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    s4  = alt ? 4'h7 : T4[y];
    if (k28 && y != 3'h3 && $countones(s4) == 2) begin
      if (!rd1) begin
        s4 = ~s4;
      end
    end else if (rd1 && ($countones(s4) != 2 || y == 3'h3)) begin
      s4 = ~s4;
    end
    rd2 = ($countones(s4) != 2) ? ~rd1 : rd1;
    enc = {rd2, s6, s4};
  endfunction

  // Reverse lookup against both disparities
  function automatic gpcs_dec_t dec(input logic [9:0] code, input logic rd);
    gpcs_dec_t  r;
    gpcs_dec_t  o;
    gpcs_char_t c;
    logic [10:0] e;
    r = '0;
    o = '0;
    for (int i = 0; i < 512; i++) begin
      c = {i[8], i[7:0]};
      if (!c.k || kvalid(c.d)) begin
        e = enc(c, rd);
        if (e[9:0] == code) begin
          r.ok = 1'b1;
          r.rd = e[10];
          r.ch = c;
        end
        e = enc(c, ~rd);
        if (e[9:0] == code) begin
          o.derr = 1'b1;
          o.rd   = e[10];
          o.ch   = c;
        end
      end
    end
    if (!r.ok) begin
      r = o;
      if (!o.derr) begin
        r.rd = rd;
      end
    end
    dec = r;
  endfunction

  // ---------------- Transmit ----------------
  gpcs_tx_st_t tx_st_r, tx_st_nxt;
  logic        tx_even_r, tx_even_nxt;
  logic        tx_rd_r, tx_rd_nxt;
  logic [9:0]  tbi_r, tbi_nxt;
  gpcs_char_t  tx_ch;
  logic [10:0] tx_enc;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_ch     = '{k: 1'b1, d: `GPCS_CH_TERM};
    case (tx_st_r)
      TX_IDLE: begin
        if (i_gmii_tx_en) begin
          tx_ch     = '{k: 1'b1, d: `GPCS_CH_START};  // [RULE2]
          tx_st_nxt = TX_DATA;
        end else if (tx_even_r) begin
          tx_ch = '{k: 1'b1, d: `GPCS_K28_5};  // [RULE4]
        end else begin
          tx_ch = '{k: 1'b0, d: tx_rd_r ? `GPCS_IDLE_D2 : `GPCS_IDLE_D1};  // [RULE4]
        end
      end
      TX_DATA: begin
        if (!i_gmii_tx_en) begin
          tx_st_nxt = TX_TERM;  // [RULE3]
        end else if (i_mac_tx_error_in) begin
          tx_ch = '{k: 1'b1, d: `GPCS_CH_ERR};  // [RULE5]
        end else begin
          tx_ch = '{k: 1'b0, d: i_gmii_txd};
        end
      end
      TX_TERM: begin
        tx_ch     = '{k: 1'b1, d: `GPCS_CH_CEXT};
        tx_st_nxt = tx_even_r ? TX_EXT : TX_IDLE;  // [RULE3]
      end
      TX_EXT: begin
        tx_ch     = '{k: 1'b1, d: `GPCS_CH_CEXT};  // [RULE3]
        tx_st_nxt = TX_IDLE;  // [RULE1]
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    tx_enc      = enc(tx_ch, tx_rd_r);  // [RULE6] [RULE23]
    tbi_nxt     = tx_enc[9:0];
    tx_rd_nxt   = tx_enc[10];
    tx_even_nxt = ~tx_even_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tx_st_r   <= TX_IDLE;
      tx_even_r <= 1'b1;
      tx_rd_r   <= `GPCS_RD_RESET;  // [RULE23]
      tbi_r     <= `GPCS_TBI_RESET;
    end else begin
      tx_st_r   <= tx_st_nxt;
      tx_even_r <= tx_even_nxt;
      tx_rd_r   <= tx_rd_nxt;
      tbi_r     <= tbi_nxt;
    end
  end

  // ---------------- Alignment and decode ----------------
  logic [9:0]  rx_prev_r;
  logic [19:0] win;
  logic [9:0]  cand [10];
  logic [9:0]  comma_at;

  assign win = {rx_prev_r, i_tbi_rx};

  for (genvar o = 0; o < 10; o++) begin : g_off
    assign cand[o]     = win[19-o -: 10];
    assign comma_at[o] = cand[o][9:3] == `GPCS_COMMA_NEG ||
                         cand[o][9:3] == `GPCS_COMMA_POS;  // [RULE7]
  end

  gpcs_sync_st_t sy_st_r, sy_st_nxt;
  logic [3:0]    off_r, off_nxt;
  logic [2:0]    cnt_r, cnt_nxt;
  logic [1:0]    good_r, good_nxt;
  logic          rx_even_r, rx_even_nxt;
  logic          rx_rd_r, rx_rd_nxt;
  logic [3:0]    first_off;
  logic          comma_here;
  logic          bad;
  gpcs_dec_t     d;

  always_comb begin
    first_off = 4'h0;
    for (int o = 9; o >= 0; o--) begin
      if (comma_at[o]) begin
        first_off = o[3:0];
      end
    end
    comma_here  = comma_at[off_r];
    d           = dec(cand[off_r], rx_rd_r);  // [RULE9] [RULE23]
    bad         = !d.ok || d.derr;
    sy_st_nxt   = sy_st_r;
    off_nxt     = off_r;
    cnt_nxt     = cnt_r;
    good_nxt    = good_r;
    rx_rd_nxt   = d.rd;
    rx_even_nxt = comma_here ? 1'b0 : ~rx_even_r;
    case (sy_st_r)
      SY_LOSS: begin
        if (|comma_at && !comma_here) begin
          off_nxt = first_off;  // [RULE7] [RULE8]
          cnt_nxt = 3'h0;
        end else if (bad) begin
          cnt_nxt = 3'h0;
        end else if (comma_here) begin
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_nxt == `GPCS_SYNC_COMMAS) begin
            sy_st_nxt = SY_ACQ;  // [RULE15]
            cnt_nxt   = 3'h0;
            good_nxt  = 2'h0;
          end
        end
      end
      SY_ACQ: begin
        rx_even_nxt = ~rx_even_r;
        if (bad || (comma_here && !rx_even_r)) begin
          cnt_nxt  = cnt_r + 3'h1;  // [RULE16]
          good_nxt = 2'h0;
          if (cnt_nxt == `GPCS_ERR_LIMIT) begin
            sy_st_nxt = SY_LOSS;  // [RULE18] [RULE8]
            cnt_nxt   = 3'h0;
          end
        end else if (cnt_r != 3'h0) begin
          good_nxt = good_r + 2'h1;
          if (good_r == `GPCS_GOOD_LAST) begin
            cnt_nxt = cnt_r - 3'h1;  // [RULE17]
          end
        end
      end
      default: sy_st_nxt = SY_LOSS;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rx_prev_r <= `GPCS_TBI_RESET;
      sy_st_r   <= SY_LOSS;
      off_r     <= 4'h0;
      cnt_r     <= 3'h0;
      good_r    <= 2'h0;
      rx_even_r <= 1'b0;
      rx_rd_r   <= `GPCS_RD_RESET;
    end else begin
      rx_prev_r <= i_tbi_rx;
      sy_st_r   <= sy_st_nxt;
      off_r     <= off_nxt;
      cnt_r     <= cnt_nxt;
      good_r    <= good_nxt;
      rx_even_r <= rx_even_nxt;
      rx_rd_r   <= rx_rd_nxt;
    end
  end

  // ---------------- Receive unwrap ----------------
  gpcs_rx_st_t rx_st_r, rx_st_nxt;
  logic        k285_r, k285_nxt;
  logic        idle_r, idle_nxt;
  logic [7:0]  rxd_r, rxd_nxt;
  logic        rxdv_r, rxdv_nxt;
  logic        rxer_r, rxer_nxt;
  logic        is_k285;
  logic        is_idle_d;

  always_comb begin
    is_k285   = d.ch.k && d.ch.d == `GPCS_K28_5 && !bad;
    is_idle_d = k285_r && !d.ch.k && !bad;
    k285_nxt  = is_k285;
    idle_nxt  = is_k285 || is_idle_d;
    rx_st_nxt = rx_st_r;
    rxd_nxt   = 8'h00;
    rxdv_nxt  = 1'b0;
    rxer_nxt  = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        if (d.ch.k && d.ch.d == `GPCS_CH_START && !bad && idle_r) begin
          rx_st_nxt = RX_FRAME;  // [RULE10]
          rxd_nxt   = `GPCS_PREAMBLE;
          rxdv_nxt  = 1'b1;
        end else if (!is_k285 && !is_idle_d) begin
          rx_st_nxt = RX_FALSE;  // [RULE13]
          rxd_nxt   = `GPCS_FALSE_CAR;
          rxer_nxt  = 1'b1;
        end
      end
      RX_FALSE: begin
        if (is_k285) begin
          rx_st_nxt = RX_IDLE;
        end else begin
          rxd_nxt  = `GPCS_FALSE_CAR;  // [RULE13]
          rxer_nxt = 1'b1;
        end
      end
      RX_FRAME: begin
        rxdv_nxt = 1'b1;
        rxd_nxt  = d.ch.d;
        if (d.ch.k && d.ch.d == `GPCS_CH_TERM && !bad) begin
          rx_st_nxt = RX_TERM;  // [RULE11]
          rxdv_nxt  = 1'b0;
          rxd_nxt   = 8'h00;
        end else if (bad || d.ch.k) begin
          rxer_nxt = 1'b1;  // [RULE12] [RULE14]
          if (is_k285) begin
            rx_st_nxt = RX_IDLE;
          end
        end
      end
      RX_TERM: begin
        if (is_k285) begin
          rx_st_nxt = RX_IDLE;  // [RULE11]
        end else if (!(d.ch.k && d.ch.d == `GPCS_CH_CEXT && !bad)) begin
          rx_st_nxt = RX_FALSE;
          rxd_nxt   = `GPCS_FALSE_CAR;
          rxer_nxt  = 1'b1;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (sy_st_r != SY_ACQ) begin
      rx_st_nxt = RX_IDLE;
      rxd_nxt   = 8'h00;
      rxdv_nxt  = 1'b0;
      rxer_nxt  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rx_st_r <= RX_IDLE;
      k285_r  <= 1'b0;
      idle_r  <= 1'b0;
      rxd_r   <= 8'h00;
      rxdv_r  <= 1'b0;
      rxer_r  <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      k285_r  <= k285_nxt;
      idle_r  <= idle_nxt;
      rxd_r   <= rxd_nxt;
      rxdv_r  <= rxdv_nxt;
      rxer_r  <= rxer_nxt;
    end
  end

  // ---------------- Indicators ----------------
  logic link_r, link_nxt;
  logic panel_r, panel_nxt;
  logic crs_r, crs_nxt;
  logic col_r, col_nxt;
  logic tx_act;
  logic rx_act;

  always_comb begin
    tx_act    = tx_st_r != TX_IDLE;
    rx_act    = rx_st_r == RX_FRAME || rx_st_r == RX_TERM;
    link_nxt  = sy_st_r == SY_ACQ;  // [RULE19]
    panel_nxt = link_nxt && !i_an_enable;  // [RULE20]
    crs_nxt   = link_nxt && (tx_act || rx_act);  // [RULE21]
    col_nxt   = i_sgmii_mode && i_half_duplex && tx_act && rx_st_r == RX_FRAME;  // [RULE22]
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      link_r  <= 1'b0;
      panel_r <= 1'b0;
      crs_r   <= 1'b0;
      col_r   <= 1'b0;
    end else begin
      link_r  <= link_nxt;
      panel_r <= panel_nxt;
      crs_r   <= crs_nxt;
      col_r   <= col_nxt;
    end
  end

  assign o_tbi_tx         = tbi_r;
  assign o_gmii_rxd       = rxd_r;
  assign o_gmii_rx_dv     = rxdv_r;
  assign o_gmii_rx_er     = rxer_r;
  assign o_rx_crs         = crs_r;
  assign o_led_crs        = crs_r;
  assign o_rx_col         = col_r;
  assign o_led_col        = col_r;
  assign o_led_link       = link_r;
  assign o_led_panel_link = panel_r;

endmodule

`default_nettype wire

//--- gpcs_map.svh
`ifndef GPCS_MAP_SVH
`define GPCS_MAP_SVH

// Special code-group byte values
`define GPCS_K28_1      8'h3C
`define GPCS_K28_5      8'hBC
`define GPCS_K28_7      8'hFC
`define GPCS_CH_START   8'hFB
`define GPCS_CH_TERM    8'hFD
`define GPCS_CH_CEXT    8'hF7
`define GPCS_CH_ERR     8'hFE
`define GPCS_IDLE_D1    8'hC5
`define GPCS_IDLE_D2    8'h50
`define GPCS_PREAMBLE   8'h55
`define GPCS_FALSE_CAR  8'h0E

// Comma patterns on the first seven bits of a symbol
`define GPCS_COMMA_NEG  7'h1F
`define GPCS_COMMA_POS  7'h60

// Synchronisation counts
`define GPCS_SYNC_COMMAS 3'h3
`define GPCS_ERR_LIMIT   3'h4
`define GPCS_GOOD_LAST   2'h3

// Reset values
`define GPCS_RD_RESET    1'b0
`define GPCS_TBI_RESET   10'h000

`endif

//--- gpcs_pkg.sv
package gpcs_pkg;

  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } gpcs_char_t;

  typedef struct packed {
    logic       ok;
    logic       derr;
    logic       rd;
    gpcs_char_t ch;
  } gpcs_dec_t;

  typedef enum {TX_IDLE, TX_DATA, TX_TERM, TX_EXT} gpcs_tx_st_t;
  typedef enum {RX_IDLE, RX_FRAME, RX_TERM, RX_FALSE} gpcs_rx_st_t;
  typedef enum {SY_LOSS, SY_ACQ} gpcs_sync_st_t;

endpackage

//--- gpcs_serdes.sv
`timescale 1ns/10ps
`default_nettype none

module gpcs_serdes (
  input  wire logic       i_clk,
  input  wire logic [9:0] i_sym,
  input  wire logic [3:0] i_slip,
  output logic      [9:0] o_tbi
);
  logic [9:0]  sym_r;
  logic [9:0]  prev_r;
  logic [19:0] pair;

  // Bit slip: each sample starts with the last i_slip bits of the older symbol
  assign pair  = {prev_r, sym_r} >> i_slip;
  assign o_tbi = pair[9:0];

  always_ff @(posedge i_clk) begin
    prev_r <= sym_r;
    sym_r  <= i_sym;
  end
endmodule

`default_nettype wire

//--- gpcs_top_sva.sv
`timescale 1ns/10ps
`default_nettype none

module gpcs_top_chk (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_gmii_txd,
  input wire logic       i_gmii_tx_en,
  input wire logic       i_mac_tx_error_in,
  input wire logic [9:0] i_tbi_rx,
  input wire logic       i_sgmii_mode,
  input wire logic       i_half_duplex,
  input wire logic       i_an_enable,
  input wire logic [9:0] o_tbi_tx,
  input wire logic [7:0] o_gmii_rxd,
  input wire logic       o_gmii_rx_dv,
  input wire logic       o_gmii_rx_er,
  input wire logic       o_rx_crs,
  input wire logic       o_rx_col,
  input wire logic       o_led_link,
  input wire logic       o_led_panel_link,
  input wire logic       o_led_crs,
  input wire logic       o_led_col
);
  logic [2:0] low_cnt_r;
  logic [2:0] low_cnt_nxt;

  // Cycles since transmit enable was last high
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    if (i_gmii_tx_en) begin
      low_cnt_nxt = 3'h0;
    end else if (low_cnt_r != 3'h7) begin
      low_cnt_nxt = low_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      low_cnt_r <= 3'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  AST_RST_IDLE: assert property (
    $rose(i_rstn) |=> o_tbi_tx == 10'h0FA)
    else $error("first symbol after reset wrong");
  AST_TX_SOF: assert property (
    i_gmii_tx_en && low_cnt_r >= 3'h4 |=> o_tbi_tx inside {10'h368, 10'h097})
    else $error("no start group");
  AST_TX_EOF: assert property (
    $fell(i_gmii_tx_en) |=> o_tbi_tx inside {10'h2E8, 10'h117}
    ##1 o_tbi_tx inside {10'h3A8, 10'h057})
    else $error("bad end sequence");
  AST_TX_IDLE: assert property (
    !i_gmii_tx_en && low_cnt_r >= 3'h4
    |=> o_tbi_tx inside {10'h0FA, 10'h305, 10'h245, 10'h1B5, 10'h296})
    else $error("non idle between frames");
  AST_TX_ERR: assert property (
    i_gmii_tx_en && $past(i_gmii_tx_en) && i_mac_tx_error_in
    |=> o_tbi_tx inside {10'h1E8, 10'h217})
    else $error("error group missing");
  AST_TX_DATA: assert property (
    i_gmii_tx_en && $past(i_gmii_tx_en) && !i_mac_tx_error_in && i_gmii_txd == 8'h55
    |=> o_tbi_tx == 10'h2A5)
    else $error("data byte misencoded");
  AST_RX_QUIET: assert property (
    !o_led_link && !$past(o_led_link) |-> !o_gmii_rx_dv && !o_gmii_rx_er)
    else $error("receive output without sync");
  AST_PANEL: assert property (
    o_led_panel_link == (o_led_link && !$past(i_an_enable)))
    else $error("panel link wrong");
  AST_CRS: assert property (
    o_led_crs == o_rx_crs && (!o_rx_crs || o_led_link))
    else $error("carrier sense wrong");
  AST_COL: assert property (
    o_rx_col |-> o_led_col && $past(i_sgmii_mode) && $past(i_half_duplex))
    else $error("collision outside half duplex");
endmodule

`default_nettype wire

//--- tb_gpcs_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_gpcs_top;
  logic       i_clk;
  logic       i_rstn;
  logic [7:0] i_gmii_txd;
  logic       i_gmii_tx_en;
  logic       i_mac_tx_error_in;
  logic [9:0] i_tbi_rx;
  logic       i_sgmii_mode;
  logic       i_half_duplex;
  logic       i_an_enable;
  logic [9:0] o_tbi_tx;
  logic [7:0] o_gmii_rxd;
  logic       o_gmii_rx_dv;
  logic       o_gmii_rx_er;
  logic       o_rx_crs;
  logic       o_rx_col;
  logic       o_led_link;
  logic       o_led_panel_link;
  logic       o_led_crs;
  logic       o_led_col;
  logic [9:0] sym;
  logic [3:0] slip;
  logic [9:0] txq[$];
  logic [8:0] rxq[$];
  logic       fc_seen;
  logic       col_seen;
  logic       crs_seen;
  logic       rl_bad;
  logic       lb;
  logic       lk;
  int         run;
  int         drops;
  int         d;
  int         miscompares;
  int         tests_run;

  gpcs_top uut (.i_clk, .i_rstn, .i_gmii_txd, .i_gmii_tx_en, .i_mac_tx_error_in,
    .i_tbi_rx, .i_sgmii_mode, .i_half_duplex, .i_an_enable, .o_tbi_tx, .o_gmii_rxd,
    .o_gmii_rx_dv, .o_gmii_rx_er, .o_rx_crs, .o_rx_col, .o_led_link,
    .o_led_panel_link, .o_led_crs, .o_led_col);
  gpcs_serdes u_ser (.i_clk, .i_sym(sym), .i_slip(slip), .o_tbi(i_tbi_rx));

  always #5 i_clk = ~i_clk;

  // Output monitor
  always @(posedge i_clk) begin
    txq.push_back(o_tbi_tx);
    if (o_gmii_rx_dv === 1'b1) begin
      rxq.push_back({o_gmii_rx_er, o_gmii_rxd});
    end
    fc_seen  = fc_seen | (!o_gmii_rx_dv && o_gmii_rx_er && o_gmii_rxd === 8'h0E);
    col_seen = col_seen | (o_rx_col === 1'b1);
    crs_seen = crs_seen | (o_gmii_rx_dv && o_rx_crs);
    if (lk && o_led_link === 1'b0) begin
      drops++;
    end
    lk = (o_led_link === 1'b1);
    if (!i_rstn || o_tbi_tx === 10'h000) begin
      run = 0;
      lb = 1'b1;
    end else begin
      for (int b = 9; b >= 0; b--) begin
        run = (o_tbi_tx[b] === lb) ? run + 1 : 1;
        lb = o_tbi_tx[b];
        rl_bad = rl_bad | (run > 5);
      end
    end
  end

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic put(input logic [9:0] s);
    @(posedge i_clk);
    #1 sym = s;
  endtask

  task automatic txb(input logic en, input logic [7:0] v, input logic er);
    @(posedge i_clk);
    #1 i_gmii_tx_en = en;
    i_gmii_txd = v;
    i_mac_tx_error_in = er;
  endtask

  task automatic idles(input int n);
    repeat (n) begin
      put(10'h0FA);
      put(10'h245);
    end
  endtask

  // Valid group, comma in odd position, then two valid groups
  task automatic bad();
    put(10'h2AA);
    put(10'h0FA);
    put(10'h245);
    put(10'h2AA);
  endtask

  task automatic sync_to();
    for (int k = 0; k < 30 && o_led_link !== 1'b1; k++) begin
      idles(1);
    end
    chk_bit(o_led_link, 1'b1);
  endtask

  task automatic rx_frame();
    rxq.delete();
    put(10'h368);
    put(10'h2A5);
    put(10'h2A6);
    put(10'h1E8);
    put(10'h3FF);
    put(10'h2AA);
    put(10'h2E8);
    put(10'h3A8);
    idles(3);
    chk_val(10'(rxq.size()), 10'h006);
    chk_val({1'b0, rxq[0]}, 10'h055);
    chk_val({1'b0, rxq[1]}, 10'h055);
    chk_val({1'b0, rxq[2]}, 10'h0D5);
    chk_bit(rxq[3][8], 1'b1);
    chk_bit(rxq[4][8], 1'b1);
    chk_val({1'b0, rxq[5]}, 10'h0B5);
  endtask

  task automatic tx_frame();
    int s;
    txq.delete();
    txb(1'b1, 8'h55, 1'b0);
    txb(1'b1, 8'h55, 1'b0);
    txb(1'b1, 8'hD5, 1'b0);
    txb(1'b1, 8'h55, 1'b1);
    txb(1'b1, 8'hD5, 1'b0);
    txb(1'b0, 8'h00, 1'b1);
    txb(1'b0, 8'h00, 1'b0);
    repeat (6) @(posedge i_clk);
    s = 0;
    while (s < 20 && !(txq[s] inside {10'h368, 10'h097})) begin
      s++;
    end
    chk_bit(txq[s] inside {10'h368, 10'h097}, 1'b1);
    chk_val(txq[s + 1], 10'h2A5);
    chk_val(txq[s + 2], 10'h2A6);
    chk_bit(txq[s + 3] inside {10'h1E8, 10'h217}, 1'b1);
    chk_val(txq[s + 4], 10'h2A6);
    chk_bit(txq[s + 5] inside {10'h2E8, 10'h117}, 1'b1);
    chk_bit(txq[s + 6] inside {10'h3A8, 10'h057}, 1'b1);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    conclude();
  end

  initial begin
    {i_clk, i_rstn, i_gmii_tx_en, i_mac_tx_error_in, i_an_enable} = 5'h00;
    {fc_seen, col_seen, crs_seen, rl_bad, lk} = 5'h00;
    {i_sgmii_mode, i_half_duplex} = 2'h3;
    run = 0;
    drops = 0;
    miscompares = 0;
    tests_run = 0;
    i_gmii_txd = 8'h00;
    sym = 10'h0FA;
    slip = 4'h3;
    repeat (3) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    idles(2);
    chk_bit(o_led_link, 1'b0);
    sync_to();
    chk_bit(o_led_panel_link, 1'b1);
    fork
      tx_frame();
      rx_frame();
    join
    chk_bit(col_seen, 1'b1);
    chk_bit(crs_seen, 1'b1);
    d = drops;
    repeat (6) begin
      bad();
      idles(2);
    end
    chk_bit(drops == d, 1'b1);
    chk_bit(fc_seen, 1'b1);
    repeat (4) bad();
    idles(2);
    chk_bit(o_led_link, 1'b0);
    slip = 4'h7;
    sync_to();
    chk_bit(drops == d + 1, 1'b1);
    i_an_enable = 1'b1;
    idles(2);
    chk_bit(o_led_panel_link, 1'b0);
    chk_bit(rl_bad, 1'b0);
    conclude();
  end
endmodule

bind gpcs_top gpcs_top_chk u_chk (.i_clk, .i_rstn, .i_gmii_txd, .i_gmii_tx_en,
  .i_mac_tx_error_in, .i_tbi_rx, .i_sgmii_mode, .i_half_duplex, .i_an_enable, .o_tbi_tx,
  .o_gmii_rxd, .o_gmii_rx_dv, .o_gmii_rx_er, .o_rx_crs, .o_rx_col, .o_led_link,
  .o_led_panel_link, .o_led_crs, .o_led_col);

`default_nettype wire
